// ==== rtl/io_pin_function_config.v ====
`timescale 1ns/1ps
`include "io_pin_function_map.vh"

// Behaviour
// RULE_01: Channel result words carry flag 0 and the channel number in bits 14-12.
// RULE_02: Temperature results carry top nibble 1000 above twelve data bits.
// RULE_03: Quarter-supply results carry top nibble 1001 above twelve data bits.
// RULE_04: Pointer 0x04 selects the conversion pin select register.
// RULE_05: Pointer 0x02 selects the conversion sequence register.
// RULE_06: Host writes address, pointer, high data byte, then low data byte.
// RULE_07: Pointer 0x40 then repeated start with read returns conversion results.
// RULE_08: Results go high byte first: flag, channel, top data; then low data.
// RULE_09: Continued reading returns the next enabled channel's result.
// RULE_10: With repeat on, enabled channels are cycled and refreshed continuously.
// RULE_11: Input select bit at one makes the pin a digital input.
// RULE_12: Output select bit at one makes the pin a digital output; reset zero.
// RULE_13: Drive type bit at one gives open-drain, zero push-pull.
// RULE_14: Output level bits drive pins low or high; reset zero.
// RULE_15: High impedance bit at one three-states the pin; reset zero.
// RULE_16: Pull-down bit at one ties the pin to ground weakly; reset ones.
// RULE_17: Current enable register at 0x0e holds four enables; upper bits reserved.
// RULE_18: An enabled current output disables that channel's voltage output.
// RULE_19: Doubled range has no effect while the current output is enabled.
// RULE_20: Host writes zeros into reserved upper bytes.
// RULE_21: Sequence bits: 9 repeat, 8 temperature, 10 supply, 7-0 channels.
// RULE_22: Enabled channels convert in ascending order.
// RULE_23: Register writes commit only after both data bytes are acknowledged.
module io_pin_function_config #(
  parameter [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT, // Bus address, arbitrary value
  parameter FIFO_DEPTH = 8,
  parameter FIFO_AW = 3
) (
  input wire CLK_I,              // 100 MHz clock
  input wire RST_N_I,            // Synchronous reset, active low
  input wire SCL_I,              // Serial clock pin
  input wire SDA_I,              // Serial data pin level
  output wire SDA_O,             // Serial data drive value
  output reg SDA_OE_O,           // Serial data drive enable
  input wire [7:0] IO_I,         // Pin levels
  output reg [7:0] IO_O,         // Pin drive values
  output reg [7:0] IO_OE_O,      // Pin drive enables
  output reg [7:0] PULLDOWN_EN_O, // Weak pull-down enables
  output reg [7:0] ADC_PIN_EN_O, // Pins routed to converter input
  output reg [7:0] GPIO_IN_O,    // Sampled digital inputs
  output reg CONV_REQ_O,         // Conversion start pulse
  output reg [3:0] CONV_CH_O,    // Conversion slot
  input wire [11:0] CONV_DATA_I, // Conversion sample
  input wire CONV_VALID_I,       // Sample ready pulse
  input wire [7:0] RANGE_X2_I,   // Requested doubled range
  output reg [7:0] RANGE_X2_EFF_O, // Effective doubled range
  output reg [7:0] VOUT_EN_O,    // Voltage output enables
  output reg [3:0] IOUT_EN_O     // Current output enables
);

  localparam [2:0] B_IDLE = 3'd0;
  localparam [2:0] B_RX = 3'd1;
  localparam [2:0] B_TX = 3'd2;
  localparam [2:0] B_WAIT_STOP = 3'd3;
  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_REQ = 2'd1;
  localparam [1:0] S_WAIT = 2'd2;
  localparam [1:0] S_PUSH = 2'd3;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------
  function [3:0] next_slot;
    input [4:0] from;
    input [9:0] mask;
    integer k;
    reg found;
    begin
      next_slot = `SLOT_NONE;
      found = 1'b0;
      for (k = 0; k < `SLOT_COUNT; k = k + 1) begin
        if (!found && (k >= from) && mask[k]) begin
          next_slot = k[3:0];
          found = 1'b1;
        end
      end
    end
  endfunction

  function [15:0] format_word;
    input [3:0] slot;
    input [11:0] data;
    begin
      if (slot == `SLOT_TEMP) begin
        format_word = {`TAG_TEMP, data};
      end else if (slot == `SLOT_SUPPLY) begin
        format_word = {`TAG_SUPPLY, data};
      end else begin
        format_word = {1'b0, slot[2:0], data};
      end
    end
  endfunction

  // ----------------------------------------------------------------------
  // Registers and internal signals
  // ----------------------------------------------------------------------
  reg [10:0] seq_reg;
  reg [7:0] pin_sel_reg, in_sel_reg, out_sel_reg, drive_type_reg, level_reg;
  reg [7:0] high_impedance_bits, pulldown_reg, shift_reg, ptr_reg, msb_hold_reg;
  reg [7:0] io_s1, io_s2;
  reg [3:0] current_en_reg, bit_cnt_reg, slot_reg;
  reg scl_s1, scl_s2, scl_s3;
  reg sda_s1, sda_s2, sda_s3;
  reg [2:0] bus_state_reg;
  reg [1:0] byte_idx_reg, seq_state_reg;
  reg ack_phase_reg, addr_read_reg, rd_low_reg, pop_reg, seq_written_reg;
  reg [15:0] rd_word_reg, result_reg, reg_rd;
  wire scl_rise, scl_fall, start_cond, stop_cond;
  wire fifo_in_ready, fifo_out_valid;
  wire [15:0] fifo_out_data, src_word;
  wire [9:0] slot_mask;
  wire [3:0] first_slot, following_slot;

  assign SDA_O = 1'b0;
  assign scl_rise = scl_s2 & ~scl_s3;
  assign scl_fall = ~scl_s2 & scl_s3;
  assign start_cond = scl_s2 & scl_s3 & sda_s3 & ~sda_s2;
  assign stop_cond = scl_s2 & scl_s3 & ~sda_s3 & sda_s2;
  assign slot_mask = {seq_reg[`SEQ_SUPPLY_BIT], seq_reg[`SEQ_TEMP_BIT], seq_reg[7:0]}; // [RULE_21]
  assign first_slot = next_slot(5'd0, slot_mask); // [RULE_22]
  assign following_slot = next_slot({1'b0, slot_reg} + 5'd1, slot_mask); // [RULE_22]
  assign src_word = (ptr_reg == `PTR_RESULT_READ) ?
                    (fifo_out_valid ? fifo_out_data : 16'h0000) : reg_rd; // [RULE_07]

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      {scl_s3, scl_s2, scl_s1} <= 3'h7;
      {sda_s3, sda_s2, sda_s1} <= 3'h7;
      {io_s2, io_s1} <= 16'h0000;
    end else begin
      {scl_s3, scl_s2, scl_s1} <= {scl_s2, scl_s1, SCL_I};
      {sda_s3, sda_s2, sda_s1} <= {sda_s2, sda_s1, SDA_I};
      {io_s2, io_s1} <= {io_s1, IO_I};
    end
  end

  // Register readback mux
  always @* begin
    case (ptr_reg)
      `PTR_SEQUENCE: reg_rd = {5'h00, seq_reg};
      `PTR_PIN_SELECT: reg_rd = {8'h00, pin_sel_reg};
      `PTR_PULLDOWN: reg_rd = {8'h00, pulldown_reg};
      `PTR_OUT_SELECT: reg_rd = {8'h00, out_sel_reg};
      `PTR_OUT_LEVEL: reg_rd = {8'h00, level_reg};
      `PTR_IN_SELECT: reg_rd = {8'h00, in_sel_reg};
      `PTR_DRIVE_TYPE: reg_rd = {8'h00, drive_type_reg};
      `PTR_HIGH_Z: reg_rd = {8'h00, high_impedance_bits};
      `PTR_CURRENT_EN: reg_rd = {12'h000, current_en_reg}; // [RULE_17]
      default: reg_rd = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------------
  // Serial bus slave and register writes
  // ----------------------------------------------------------------------
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      {bus_state_reg, bit_cnt_reg, byte_idx_reg} <= {B_IDLE, 6'h00};
      {rd_word_reg, shift_reg, ptr_reg, msb_hold_reg} <= 40'h0000000000;
      {ack_phase_reg, addr_read_reg, rd_low_reg, pop_reg, seq_written_reg, SDA_OE_O} <= 6'h00;
      seq_reg <= `RST_SEQUENCE;
      {pin_sel_reg, in_sel_reg} <= {2{`RST_BYTE_ZERO}};
      out_sel_reg <= `RST_BYTE_ZERO; // [RULE_12]
      drive_type_reg <= `RST_BYTE_ZERO; // [RULE_13]
      level_reg <= `RST_BYTE_ZERO; // [RULE_14]
      high_impedance_bits <= `RST_BYTE_ZERO; // [RULE_15]
      pulldown_reg <= `RST_PULLDOWN; // [RULE_16]
      current_en_reg <= `RST_CURRENT_EN;
    end else begin
      pop_reg <= 1'b0;
      seq_written_reg <= 1'b0;
      if (start_cond) begin
        // Start or repeated start keeps the pointer
        bus_state_reg <= B_RX;
        bit_cnt_reg <= 4'h0;
        ack_phase_reg <= 1'b0;
        byte_idx_reg <= 2'd0;
        SDA_OE_O <= 1'b0;
      end else if (stop_cond) begin
        bus_state_reg <= B_IDLE;
        SDA_OE_O <= 1'b0;
      end else if (scl_rise) begin
        if (ack_phase_reg) begin
          // Host acknowledge after a sent byte; high means end of read
          if (bus_state_reg == B_TX && sda_s2) begin
            bus_state_reg <= B_WAIT_STOP;
          end
        end else if (bus_state_reg == B_RX) begin
          shift_reg <= {shift_reg[6:0], sda_s2};
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end else if (bus_state_reg == B_TX) begin
          bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
      end else if (scl_fall) begin
        if (!ack_phase_reg && bit_cnt_reg == 4'h8) begin
          ack_phase_reg <= 1'b1;
          if (bus_state_reg == B_TX) begin
            SDA_OE_O <= 1'b0;
          end else if (bus_state_reg == B_RX) begin
            SDA_OE_O <= 1'b1;
            if (byte_idx_reg == 2'd0) begin
              if (shift_reg[7:1] == DEV_ADDR) begin
                addr_read_reg <= shift_reg[0];
              end else begin
                SDA_OE_O <= 1'b0;
                bus_state_reg <= B_WAIT_STOP;
              end
            end else if (byte_idx_reg == 2'd1) begin
              ptr_reg <= shift_reg; // [RULE_04] [RULE_05]
            end else if (byte_idx_reg == 2'd2) begin
              msb_hold_reg <= shift_reg; // [RULE_06]
            end else begin
              // Commit on the low byte; upper byte is reserved except sequence bits 10-8 [RULE_23] [RULE_20]
              case (ptr_reg)
                `PTR_SEQUENCE: begin
                  seq_reg <= {msb_hold_reg[2:0], shift_reg}; // [RULE_05] [RULE_21]
                  seq_written_reg <= 1'b1;
                end
                `PTR_PIN_SELECT: pin_sel_reg <= shift_reg; // [RULE_04]
                `PTR_PULLDOWN: pulldown_reg <= shift_reg;
                `PTR_OUT_SELECT: out_sel_reg <= shift_reg;
                `PTR_OUT_LEVEL: level_reg <= shift_reg;
                `PTR_IN_SELECT: in_sel_reg <= shift_reg;
                `PTR_DRIVE_TYPE: drive_type_reg <= shift_reg;
                `PTR_HIGH_Z: high_impedance_bits <= shift_reg;
                `PTR_CURRENT_EN: current_en_reg <= shift_reg[3:0]; // [RULE_17]
                default: current_en_reg <= current_en_reg;
              endcase
            end
          end
        end else if (ack_phase_reg) begin
          ack_phase_reg <= 1'b0;
          bit_cnt_reg <= 4'h0;
          SDA_OE_O <= 1'b0;
          if (bus_state_reg == B_RX) begin
            if (byte_idx_reg == 2'd0 && addr_read_reg) begin
              // Read begins with the high byte of the word [RULE_07] [RULE_08]
              bus_state_reg <= B_TX;
              rd_word_reg <= src_word;
              shift_reg <= src_word[15:8];
              SDA_OE_O <= ~src_word[15];
              rd_low_reg <= 1'b1;
              pop_reg <= (ptr_reg == `PTR_RESULT_READ) & fifo_out_valid;
            end else if (byte_idx_reg != 2'd3) begin
              byte_idx_reg <= byte_idx_reg + 2'd1;
            end else begin
              // Further bytes restart the high/low pairing
              byte_idx_reg <= 2'd2;
            end
          end else if (bus_state_reg == B_TX) begin
            if (rd_low_reg) begin
              shift_reg <= rd_word_reg[7:0]; // [RULE_08]
              SDA_OE_O <= ~rd_word_reg[7];
              rd_low_reg <= 1'b0;
            end else begin
              // Next word of the block read [RULE_09] [RULE_10]
              rd_word_reg <= src_word;
              shift_reg <= src_word[15:8];
              SDA_OE_O <= ~src_word[15];
              rd_low_reg <= 1'b1;
              pop_reg <= (ptr_reg == `PTR_RESULT_READ) & fifo_out_valid;
            end
          end
        end else if (bus_state_reg == B_TX && bit_cnt_reg != 4'h0) begin
          shift_reg <= {shift_reg[6:0], 1'b0};
          SDA_OE_O <= ~shift_reg[6];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------------
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      seq_state_reg <= S_IDLE;
      {CONV_REQ_O, CONV_CH_O, slot_reg, result_reg} <= 25'h0000000;
    end else begin
      CONV_REQ_O <= 1'b0;
      if (seq_written_reg) begin
        // New sequence drops the old one and starts at once
        slot_reg <= first_slot; // [RULE_22]
        seq_state_reg <= (first_slot != `SLOT_NONE) ? S_REQ : S_IDLE;
      end else begin
        case (seq_state_reg)
          S_IDLE: seq_state_reg <= S_IDLE;
          S_REQ: begin
            CONV_REQ_O <= 1'b1;
            CONV_CH_O <= slot_reg;
            seq_state_reg <= S_WAIT;
          end
          S_WAIT: begin
            if (CONV_VALID_I) begin
              result_reg <= format_word(slot_reg, CONV_DATA_I); // [RULE_01] [RULE_02] [RULE_03]
              seq_state_reg <= S_PUSH;
            end
          end
          S_PUSH: begin
            // Stalls while the buffer is full
            if (fifo_in_ready) begin
              if (following_slot != `SLOT_NONE) begin
                slot_reg <= following_slot; // [RULE_22]
                seq_state_reg <= S_REQ;
              end else if (seq_reg[`SEQ_REPEAT_BIT] && first_slot != `SLOT_NONE) begin
                slot_reg <= first_slot; // [RULE_10]
                seq_state_reg <= S_REQ;
              end else begin
                seq_state_reg <= S_IDLE;
              end
            end
          end
          default: seq_state_reg <= S_IDLE;
        endcase
      end
    end
  end

  result_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_result_fifo (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .in_valid_i(seq_state_reg == S_PUSH),
    .in_ready_o(fifo_in_ready),
    .in_data_i(result_reg),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(pop_reg),
    .out_data_o(fifo_out_data)
  );

  // ----------------------------------------------------------------------
  // Pin function outputs
  // ----------------------------------------------------------------------
  always @(posedge CLK_I) begin
    if (!RST_N_I) begin
      {IO_O, IO_OE_O, ADC_PIN_EN_O, GPIO_IN_O} <= {4{`RST_BYTE_ZERO}};
      {RANGE_X2_EFF_O, VOUT_EN_O, IOUT_EN_O} <= {`RST_BYTE_ZERO, `RST_BYTE_ZERO, `RST_CURRENT_EN};
      PULLDOWN_EN_O <= `RST_PULLDOWN;
    end else begin
      IO_O <= level_reg; // [RULE_14]
      // Open-drain drives only the low level; three-state wins [RULE_12] [RULE_13] [RULE_15]
      IO_OE_O <= out_sel_reg & ~high_impedance_bits & ~(drive_type_reg & level_reg);
      PULLDOWN_EN_O <= pulldown_reg; // [RULE_16]
      ADC_PIN_EN_O <= pin_sel_reg; // [RULE_04]
      GPIO_IN_O <= io_s2 & in_sel_reg; // [RULE_11]
      IOUT_EN_O <= current_en_reg; // [RULE_17]
      VOUT_EN_O <= ~(out_sel_reg | in_sel_reg | pin_sel_reg | high_impedance_bits) &
                   ~{4'h0, current_en_reg}; // [RULE_18]
      RANGE_X2_EFF_O <= RANGE_X2_I & ~{4'h0, current_en_reg}; // [RULE_19]
    end
  end

endmodule

// ==== inc/io_pin_function_map.vh ====
`ifndef IO_PIN_FUNCTION_MAP_VH
`define IO_PIN_FUNCTION_MAP_VH

// ----------------------------------------------------------------------
// Pointer byte values
// ----------------------------------------------------------------------
`define PTR_SEQUENCE 8'h02
`define PTR_PIN_SELECT 8'h04
`define PTR_PULLDOWN 8'h06
`define PTR_OUT_SELECT 8'h07
`define PTR_OUT_LEVEL 8'h08
`define PTR_IN_SELECT 8'h0a
`define PTR_DRIVE_TYPE 8'h0c
`define PTR_HIGH_Z 8'h0d
`define PTR_CURRENT_EN 8'h0e
`define PTR_RESULT_READ 8'h40

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_SEQUENCE 11'h000
`define RST_BYTE_ZERO 8'h00
`define RST_PULLDOWN 8'hff
`define RST_CURRENT_EN 4'h0

// ----------------------------------------------------------------------
// Sequence register fields
// ----------------------------------------------------------------------
`define SEQ_TEMP_BIT 8
`define SEQ_REPEAT_BIT 9
`define SEQ_SUPPLY_BIT 10

// ----------------------------------------------------------------------
// Result word layout and conversion slots
// ----------------------------------------------------------------------
`define TAG_TEMP 4'h8
`define TAG_SUPPLY 4'h9
`define SLOT_TEMP 4'h8
`define SLOT_SUPPLY 4'h9
`define SLOT_NONE 4'hf
`define SLOT_COUNT 10

// ----------------------------------------------------------------------
// Bus address, arbitrary default
// ----------------------------------------------------------------------
`define DEV_ADDR_DEFAULT 7'h48

`endif

// ==== rtl/result_fifo.v ====
`timescale 1ns/1ps

module result_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk_i,              // System clock
  input wire rst_n_i,            // Synchronous reset, active low
  input wire in_valid_i,         // Write request
  output wire in_ready_o,        // Space available
  input wire [WIDTH-1:0] in_data_i, // Write word
  output wire out_valid_o,       // Word available
  input wire out_ready_i,        // Read acknowledge
  output wire [WIDTH-1:0] out_data_o // Head word
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0] count_reg;
  wire push;
  wire pop;

  // ----------------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------------
  assign in_ready_o = (count_reg != DEPTH[AW:0]);
  assign out_valid_o = (count_reg != {(AW+1){1'b0}});
  assign push = in_valid_i & in_ready_o;
  assign pop = out_ready_i & out_valid_o;
  assign out_data_o = mem[rd_ptr_reg];

  // Storage array
  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  // Pointers and fill level
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end

endmodule

// ==== test/io_pin_function_config_monitor.sv ====
`timescale 1ns/1ps
module io_pin_function_config_monitor (
  input wire CLK_I, // Clock
  input wire RST_N_I, // Reset
  input wire SCL_I, // Serial clock
  input wire SDA_OE_O, // Data pull
  input wire [7:0] IO_O, // Levels
  input wire [7:0] IO_OE_O, // Drive enables
  input wire [7:0] PULLDOWN_EN_O, // Pull-downs
  input wire [7:0] ADC_PIN_EN_O, // Analog pins
  input wire [7:0] GPIO_IN_O, // Inputs
  input wire CONV_REQ_O, // Start pulse
  input wire [3:0] CONV_CH_O, // Slot
  input wire [7:0] RANGE_X2_I, // Range asked
  input wire [7:0] RANGE_X2_EFF_O, // Range used
  input wire [7:0] VOUT_EN_O, // Voltage outputs
  input wire [3:0] IOUT_EN_O // Current outputs
);
  // One clock domain for all checks
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);
  // Reset values at the first edge after release
  AST_PD_RST: assert property ($rose(RST_N_I) |-> PULLDOWN_EN_O == 8'hff)
    else $error("pull-down reset value wrong");
  AST_OUT_RST: assert property ($rose(RST_N_I) |-> IO_OE_O == 8'h00 && IO_O == 8'h00)
    else $error("output reset value wrong");
  // Voltage output excludes the other pin functions; current output masks doubled range
  AST_IOUT_VOUT: assert property ((VOUT_EN_O[3:0] & IOUT_EN_O) == 4'h0)
    else $error("voltage output on with current output");
  AST_RANGE: assert property ($past(RST_N_I) |->
    RANGE_X2_EFF_O == ($past(RANGE_X2_I) & ~{4'h0, IOUT_EN_O}))
    else $error("doubled range wrong");
  AST_OUT_VOUT: assert property ((IO_OE_O & VOUT_EN_O) == 8'h00)
    else $error("digital output with voltage output");
  AST_ADC_VOUT: assert property ((ADC_PIN_EN_O & VOUT_EN_O) == 8'h00)
    else $error("analog input with voltage output");
  AST_IN_VOUT: assert property ((GPIO_IN_O & VOUT_EN_O) == 8'h00)
    else $error("digital input with voltage output");
  // Requests name a real slot and last one cycle
  AST_SLOT: assert property (CONV_REQ_O |-> CONV_CH_O <= 4'h9 ##1 !CONV_REQ_O)
    else $error("bad conversion request");
  // Data line only moves while the serial clock is low
  AST_SDA_CLK: assert property ($changed(SDA_OE_O) |-> !SCL_I)
    else $error("data changed with clock high");
endmodule
bind io_pin_function_config io_pin_function_config_monitor i_mon (
  .CLK_I(CLK_I), .RST_N_I(RST_N_I), .SCL_I(SCL_I), .SDA_OE_O(SDA_OE_O),
  .IO_O(IO_O), .IO_OE_O(IO_OE_O), .PULLDOWN_EN_O(PULLDOWN_EN_O),
  .ADC_PIN_EN_O(ADC_PIN_EN_O), .GPIO_IN_O(GPIO_IN_O), .CONV_REQ_O(CONV_REQ_O),
  .CONV_CH_O(CONV_CH_O), .RANGE_X2_I(RANGE_X2_I), .RANGE_X2_EFF_O(RANGE_X2_EFF_O),
  .VOUT_EN_O(VOUT_EN_O), .IOUT_EN_O(IOUT_EN_O));

// ==== test/i2c_host_model.sv ====
`timescale 1ns/1ps
`include "io_pin_function_map.vh"
module i2c_host_model (
  input wire clk_i, // System clock
  input wire sda_i, // Resolved data wire
  output reg scl_o, // Serial clock, idles high
  output reg sda_low_o // Host pulls data low
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  // Eight clocks per bus phase
  task automatic q;
    repeat (8) @(posedge clk_i);
  endtask
  // One bit, data set while the clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_low_o <= !b;
    q;
    scl_o <= 1'b1;
    q;
    r = sda_i;
    scl_o <= 1'b0;
    q;
  endtask
  // Start, or repeated start from clock low
  task automatic start_c;
    sda_low_o <= 1'b0;
    q;
    scl_o <= 1'b1;
    q;
    sda_low_o <= 1'b1;
    q;
    scl_o <= 1'b0;
    q;
  endtask
  // Stop, bus left idle
  task automatic stop_c;
    sda_low_o <= 1'b1;
    q;
    scl_o <= 1'b1;
    q;
    sda_low_o <= 1'b0;
    q;
  endtask
  // Byte out, top bit first
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask
  // Byte in, acknowledged unless last
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
  // Register write: address, pointer, high byte, low byte
  task automatic write16(input logic [7:0] ptr, input logic [15:0] v);
    logic a;
    start_c;
    wr_byte({`DEV_ADDR_DEFAULT, 1'b0}, a);
    wr_byte(ptr, a);
    wr_byte(v[15:8], a);
    wr_byte(v[7:0], a);
    stop_c;
  endtask
  // Pointer write, then repeated start with read bit
  task automatic open_read(input logic [7:0] ptr, output logic ack);
    logic a;
    start_c;
    wr_byte({`DEV_ADDR_DEFAULT, 1'b0}, a);
    wr_byte(ptr, a);
    start_c;
    wr_byte({`DEV_ADDR_DEFAULT, 1'b1}, ack);
  endtask
endmodule

// ==== test/io_pin_function_config_tb_top.sv ====
`timescale 1ns/1ps
`include "io_pin_function_map.vh"
module io_pin_function_config_tb_top;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] io_in = 8'ha5;
  reg [7:0] range_x2 = 8'hff;
  reg [11:0] conv_data = 12'h000;
  reg conv_valid = 1'b0;
  reg [3:0] cap_ch = 4'h0;
  reg [2:0] dly = 3'h0;
  wire scl, host_low, sda_oe, sda_o, conv_req;
  wire sda = !(sda_oe | host_low);
  wire [7:0] io_o, io_oe, pd_en, adc_en, gpio_in, range_eff, vout_en;
  wire [3:0] conv_ch, iout_en;
  logic [3:0] slots [0:3] = '{4'h0, 4'h7, 4'h8, 4'h9};
  int num_errors = 0;
  int check_count = 0;
  io_pin_function_config i_dut (
    .CLK_I(clk), .RST_N_I(rst_n), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE_O(sda_oe), .IO_I(io_in), .IO_O(io_o), .IO_OE_O(io_oe),
    .PULLDOWN_EN_O(pd_en), .ADC_PIN_EN_O(adc_en), .GPIO_IN_O(gpio_in),
    .CONV_REQ_O(conv_req), .CONV_CH_O(conv_ch), .CONV_DATA_I(conv_data),
    .CONV_VALID_I(conv_valid), .RANGE_X2_I(range_x2), .RANGE_X2_EFF_O(range_eff),
    .VOUT_EN_O(vout_en), .IOUT_EN_O(iout_en));
  i2c_host_model i_host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_low_o(host_low));
  initial begin
    forever #5 clk = ~clk;
  end
  // Converter stand-in: sample three clocks after each request
  always @(posedge clk) begin
    conv_valid <= 1'b0;
    if (conv_req) begin
      cap_ch <= conv_ch;
      dly <= 3'h3;
    end else if (dly != 3'h0) begin
      dly <= dly - 3'h1;
      conv_valid <= (dly == 3'h1);
      conv_data <= {cap_ch, 8'h5a};
    end
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic t_reset;
    check("pulldown", pd_en, 16'h00ff);
    check("io_oe", io_oe, 16'h0000);
    check("io_o", io_o, 16'h0000);
    check("iout", iout_en, 16'h0000);
  endtask
  // Reserved enable bits written high must drop
  task automatic t_current;
    i_host.write16(`PTR_CURRENT_EN, 16'h00f3);
    @(negedge clk);
    check("iout", iout_en, 16'h0003);
    check("vout", vout_en, 16'h00fc);
    check("range", range_eff, 16'h00fc);
  endtask
  task automatic t_gpio;
    i_host.write16(`PTR_OUT_SELECT, 16'h000f);
    i_host.write16(`PTR_OUT_LEVEL, 16'h0005);
    i_host.write16(`PTR_DRIVE_TYPE, 16'h0001);
    i_host.write16(`PTR_HIGH_Z, 16'h0002);
    i_host.write16(`PTR_PULLDOWN, 16'h0000);
    i_host.write16(`PTR_IN_SELECT, 16'h00f0);
    @(negedge clk);
    check("io_oe", io_oe, 16'h000c);
    check("io_o", io_o, 16'h0005);
    check("pulldown", pd_en, 16'h0000);
    check("gpio_in", gpio_in, 16'h00a0);
  endtask
  // Write cut off after one data byte
  task automatic t_partial;
    logic ack;
    i_host.start_c;
    i_host.wr_byte({`DEV_ADDR_DEFAULT, 1'b0}, ack);
    check("ack", ack, 16'h0001);
    i_host.wr_byte(`PTR_OUT_LEVEL, ack);
    i_host.wr_byte(8'hff, ack);
    i_host.stop_c;
    @(negedge clk);
    check("io_o", io_o, 16'h0005);
  endtask
  // Register readback through a plain pointer
  task automatic t_readback;
    logic ack;
    logic [7:0] hi;
    logic [7:0] lo;
    i_host.open_read(`PTR_DRIVE_TYPE, ack);
    i_host.rd_byte(1'b0, hi);
    i_host.rd_byte(1'b1, lo);
    i_host.stop_c;
    check("readback", {hi, lo}, 16'h0001);
  endtask
  // Block read past the buffer depth with repeat on
  task automatic t_adc;
    logic ack;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [15:0] exp;
    i_host.write16(`PTR_PIN_SELECT, 16'h0081);
    @(negedge clk);
    check("adc_pins", adc_en, 16'h0081);
    i_host.write16(`PTR_SEQUENCE, 16'h0781);
    i_host.open_read(`PTR_RESULT_READ, ack);
    check("ack", ack, 16'h0001);
    for (int i = 0; i < 12; i++) begin
      i_host.rd_byte(1'b0, hi);
      i_host.rd_byte(i == 11, lo);
      exp = {slots[i % 4], slots[i % 4], 8'h5a};
      check("result", {hi, lo}, exp);
    end
    i_host.stop_c;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    t_reset;
    t_current;
    t_gpio;
    t_partial;
    t_readback;
    t_adc;
    final_report;
  end
  // Hang guard
  initial begin
    repeat (60000) @(posedge clk);
    num_errors++;
    final_report;
  end
endmodule
